// ---- core/alcci_pkg.sv ----
// Purpose: shared constants and types of the channel config and irq block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   channel offsets repeat with a fixed stride
package alcci_pkg;
  localparam logic [7:0]  OFF_MODE     = 8'h00;
  localparam logic [7:0]  OFF_STAT     = 8'h04;
  localparam logic [7:0]  OFF_TXHOLD   = 8'h08;
  localparam logic [7:0]  OFF_RXHOLD   = 8'h0c;
  localparam logic [7:0]  CHAN_STRIDE  = 8'h10;
  localparam logic [7:0]  OFF_GSTAT    = 8'h30;
  localparam logic [7:0]  OFF_IEN      = 8'h34;
  localparam logic [7:0]  OFF_IDIS     = 8'h38;
  localparam logic [7:0]  OFF_IMASK    = 8'h3c;
  localparam int          BIT_TX_FREE  = 0;
  localparam int          BIT_TX_DRAIN = 1;
  localparam int          BIT_TX_UNDER = 2;
  localparam int          BIT_RX_FULL  = 4;
  localparam int          BIT_RX_OVER  = 5;
  localparam int          BIT_TX_CDONE = 10;
  localparam int          BIT_TX_CEXH  = 11;
  localparam int          BIT_RX_CDONE = 14;
  localparam int          BIT_RX_CEXH  = 15;
  localparam int          POS_SIZE     = 16;
  localparam int          POS_ENDIAN   = 18;
  localparam int          POS_XFER_ON  = 21;
  localparam int          POS_DMA      = 22;
  localparam logic [31:0] WMASK_A      = 32'h0067_cc37;
  localparam logic [31:0] WMASK_B      = 32'h0027_0037;
  localparam logic [31:0] WMASK_CODEC  = 32'h0000_0037;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam int          GS_SOF       = 0;
  localparam int          GS_WAKE      = 1;
  localparam int          GS_CODEC     = 2;
  localparam int          GS_CHA       = 3;
  localparam int          GS_CHB       = 4;
  localparam int          GS_W         = 5;
  localparam logic [4:0]  IMASK_RESET  = 5'h00;
  localparam int          SLOT_W       = 20;
  localparam int          NCHAN        = 3;
  typedef enum logic [1:0] {KIND_A, KIND_B, KIND_CODEC} alcci_kind_t;
  // low slot bits left empty for each sample width code
  function automatic logic [4:0] dropBits(input logic [1:0] size);
    case (size)
      2'h0:    dropBits = 5'h00;
      2'h1:    dropBits = 5'h02;
      2'h2:    dropBits = 5'h04;
      default: dropBits = 5'h0a;
    endcase
  endfunction
  function automatic logic [31:0] byteSwap(input logic [31:0] w);
    byteSwap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// ---- core/alcci_chan_if.sv ----
// Purpose: register side carrier between the top and one channel
// Assumes: all signals on core_clk
// Notes:   strobes are one cycle pulses from the register decoder
`timescale 1ns/10ps
interface alcci_chan_if;
  logic        modeWr;
  logic        stRd;
  logic        txWr;
  logic        rxRd;
  logic [31:0] wdata;
  logic [31:0] modeQ;
  logic [31:0] statQ;
  logic [31:0] rxHoldQ;
  logic        evt;
  modport ctl  (output modeWr, stRd, txWr, rxRd, wdata, input modeQ, statQ, rxHoldQ, evt);
  modport chan (input modeWr, stRd, txWr, rxRd, wdata, output modeQ, statQ, rxHoldQ, evt);
endinterface

// ---- core/alcci_chan.sv ----
// Purpose: one channel: mode register, holding registers, status and event
// Assumes: slot strobes come from framing logic on core_clk
// Notes:   a write to a full transmit holding register overwrites it
`timescale 1ns/10ps
module alcci_chan #(
  parameter alcci_pkg::alcci_kind_t KIND = alcci_pkg::KIND_A
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  alcci_chan_if.chan       ctl,
  input  wire logic        slotReq,
  input  wire logic        slotRxValid,
  input  wire logic [19:0] slotRxData,
  input  wire logic        varRateOn,
  input  wire logic [3:0]  dmaFlags,
  output logic      [19:0] slotTxData,
  output logic             slotTxValid,
  output logic             dmaTxReq,
  output logic             dmaRxReq
);
  localparam logic [31:0] WMASK = (KIND == alcci_pkg::KIND_A) ? alcci_pkg::WMASK_A :
                                  (KIND == alcci_pkg::KIND_B) ? alcci_pkg::WMASK_B : alcci_pkg::WMASK_CODEC;
  logic [31:0] modeQ;
  logic [31:0] txHoldQ;
  logic [31:0] rxHoldQ;
  logic        txFullQ;
  logic        txDrainQ;
  logic        underQ;
  logic        rxFullQ;
  logic        overQ;
  logic        eventQ;
  logic [31:0] statD;
  logic [31:0] txWord;
  logic [31:0] rxWord;
  logic [4:0]  drop;
  logic        xferOn;
  logic        route;
  logic        take;
  logic        rxLoad;
  // the codec channel has no control fields and always runs at full width
  assign xferOn = (KIND == alcci_pkg::KIND_CODEC) | modeQ[alcci_pkg::POS_XFER_ON];
  assign route  = modeQ[alcci_pkg::POS_DMA];
  assign drop   = alcci_pkg::dropBits(modeQ[alcci_pkg::POS_SIZE +: 2]);
  assign take   = slotReq & xferOn & txFullQ;
  assign rxLoad = slotRxValid & xferOn;
  assign txWord = modeQ[alcci_pkg::POS_ENDIAN] ? alcci_pkg::byteSwap(txHoldQ) : txHoldQ;
  assign rxWord = {12'h000, slotRxData} >> drop;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeQ <= alcci_pkg::MODE_RESET;
    end else if (ctl.modeWr) begin
      modeQ <= ctl.wdata & WMASK;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txHoldQ  <= 32'h0000_0000;
      txFullQ  <= 1'b0;
      txDrainQ <= 1'b0;
    end else begin
      if (ctl.txWr && xferOn) begin
        txHoldQ <= ctl.wdata;
      end
      txFullQ  <= (ctl.txWr & xferOn) | (txFullQ & ~take);
      txDrainQ <= ~(ctl.txWr & xferOn) & (take | txDrainQ);
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slotTxData  <= 20'h00000;
      slotTxValid <= 1'b0;
    end else begin
      slotTxValid <= take;
      slotTxData  <= take ? 20'((txWord << drop) & 32'h000f_ffff) : 20'h00000;
    end
  end
  // cleared by status read, set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      underQ <= 1'b0;
      overQ  <= 1'b0;
    end else begin
      underQ <= (slotReq & xferOn & ~txFullQ & varRateOn) | (underQ & ~ctl.stRd);
      overQ  <= (rxLoad & rxFullQ & ~ctl.rxRd) | (overQ & ~ctl.stRd);
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxHoldQ <= 32'h0000_0000;
      rxFullQ <= 1'b0;
    end else begin
      if (rxLoad) begin
        rxHoldQ <= modeQ[alcci_pkg::POS_ENDIAN] ? alcci_pkg::byteSwap(rxWord) : rxWord;
      end
      rxFullQ <= rxLoad | (rxFullQ & ~ctl.rxRd);
    end
  end
  always_comb begin
    statD = 32'h0000_0000;
    statD[alcci_pkg::BIT_TX_FREE]  = ~txFullQ;
    statD[alcci_pkg::BIT_TX_DRAIN] = txDrainQ;
    statD[alcci_pkg::BIT_TX_UNDER] = underQ;
    statD[alcci_pkg::BIT_RX_FULL]  = rxFullQ;
    statD[alcci_pkg::BIT_RX_OVER]  = overQ;
    statD[alcci_pkg::BIT_TX_CDONE] = route & dmaFlags[0];
    statD[alcci_pkg::BIT_TX_CEXH]  = route & dmaFlags[1];
    statD[alcci_pkg::BIT_RX_CDONE] = route & dmaFlags[2];
    statD[alcci_pkg::BIT_RX_CEXH]  = route & dmaFlags[3];
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eventQ   <= 1'b0;
      dmaTxReq <= 1'b0;
      dmaRxReq <= 1'b0;
    end else begin
      eventQ   <= |(statD & modeQ & 32'h0000_ffff);
      dmaTxReq <= route & xferOn & ~txFullQ;
      dmaRxReq <= route & xferOn & rxFullQ;
    end
  end
  assign ctl.modeQ   = modeQ;
  assign ctl.statQ   = statD;
  assign ctl.rxHoldQ = rxHoldQ;
  assign ctl.evt     = eventQ;
  a_event_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    eventQ == $past(|(statD & modeQ & 32'h0000_ffff))) else $error("event flag off");
  a_slot_justify: assert property (@(posedge core_clk) disable iff (!arst_n)
    slotTxValid |-> ((32'(slotTxData) & ((32'h1 << $past(drop)) - 32'h1)) == 32'h0))
    else $error("slot low bits not zero");
  a_xfer_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    !xferOn |=> !slotTxValid) else $error("slot sent while disabled");
endmodule

// ---- core/alcci_top.sv ----
// Purpose: channel config, global status and interrupt mask of the link controller
// Assumes: link pins are asynchronous to core_clk; bit clock much slower than core_clk
// Notes:   read data stand only in the cycle after a read strobe, zero otherwise
// Notes on behaviour
// - endian bit 1 byte-swaps channel words between memory and link
// - width code 0..3 selects 20, 18, 16 or 10 bit samples
// - slots are 20 bits, sample msb-justified, low bits zero
// - channels A and B move data only while their enable bit is set; the codec channel always does
// - dma routing bit enables dma flags and requests, else suppressed
// - mode mask bits 0,1,2,4,5 read back and gate channel events
// - dma event mask bits behave like other mask bits
// - reading global status clears wake and frame start flags
// - frame start flag set when a frame start seen since last read
// - wake flag set on rising edge of codec serial input
// - codec event high while codec status and mask overlap
// - channel A event high while its status and mask overlap
// - channel B event high while its status and mask overlap
// - enable-set register ones set global mask bits
// - enable-clear register ones clear global mask bits
// - mask view register reads current global mask
// - status read clears overflow and underflow; underflow only in variable rate
// - receive holding full flag shows loaded receive data
`timescale 1ns/10ps
module alcci_top (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdata,
  input  wire logic             bitClkPin,
  input  wire logic             syncPin,
  input  wire logic             sdataInPin,
  input  wire logic             varRateOn,
  input  wire logic [3:0]       dmaFlagsA,
  input  wire logic [2:0]       slotReq,
  input  wire logic [2:0]       slotRxValid,
  input  wire logic [2:0][19:0] slotRxData,
  output wire logic [2:0][19:0] slotTxData,
  output wire logic [2:0]       slotTxValid,
  output wire logic [2:0]       dmaTxReq,
  output wire logic [2:0]       dmaRxReq,
  output logic                  irqOut
);
  // pin index: 0 bit clock, 1 sync, 2 serial input
  logic [2:0]  pinS1Q;
  logic [2:0]  pinS2Q;
  logic [2:0]  pinS3Q;
  logic [2:0]  pinFiltQ;
  logic [2:0]  pinPrevQ;
  logic        syncSmpQ;
  logic        frameStart;
  logic        wakeRise;
  logic        sofQ;
  logic        wakeQ;
  logic [4:0]  imaskQ;
  logic        irqQ;
  logic [4:0]  gstat;
  logic        gstatRead;
  logic        ienWr;
  logic        idisWr;
  logic [31:0] rdD;
  logic [31:0] modeV [alcci_pkg::NCHAN];
  logic [31:0] statV [alcci_pkg::NCHAN];
  logic [31:0] rxV   [alcci_pkg::NCHAN];
  logic [2:0]  evtV;
  alcci_chan_if chIf [alcci_pkg::NCHAN] ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // three stage sync; the filtered level only moves when stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinS1Q   <= 3'h0;
      pinS2Q   <= 3'h0;
      pinS3Q   <= 3'h0;
      pinFiltQ <= 3'h0;
      pinPrevQ <= 3'h0;
    end else begin
      pinS1Q   <= {sdataInPin, syncPin, bitClkPin};
      pinS2Q   <= pinS1Q;
      pinS3Q   <= pinS2Q;
      pinFiltQ <= (pinS2Q & pinS3Q) | (pinFiltQ & (pinS2Q | pinS3Q));
      pinPrevQ <= pinFiltQ;
    end
  end

  // sync is only meaningful at bit clock rising edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncSmpQ <= 1'b0;
    end else if (pinFiltQ[0] && !pinPrevQ[0]) begin
      syncSmpQ <= pinFiltQ[1];
    end
  end
  assign frameStart = pinFiltQ[0] & ~pinPrevQ[0] & pinFiltQ[1] & ~syncSmpQ;
  // wake edges are seen even while the bit clock stands still
  assign wakeRise   = pinFiltQ[2] & ~pinPrevQ[2];

  assign gstatRead = regRd & hit(regAddr, alcci_pkg::OFF_GSTAT);
  assign ienWr     = regWr & hit(regAddr, alcci_pkg::OFF_IEN);
  assign idisWr    = regWr & hit(regAddr, alcci_pkg::OFF_IDIS);

  // read clears, a new event in the same cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sofQ  <= 1'b0;
      wakeQ <= 1'b0;
    end else begin
      sofQ  <= frameStart | (sofQ & ~gstatRead);
      wakeQ <= wakeRise | (wakeQ & ~gstatRead);
    end
  end

  always_comb begin
    gstat = 5'h00;
    gstat[alcci_pkg::GS_SOF]   = sofQ;
    gstat[alcci_pkg::GS_WAKE]  = wakeQ;
    gstat[alcci_pkg::GS_CODEC] = evtV[2];
    gstat[alcci_pkg::GS_CHA]   = evtV[0];
    gstat[alcci_pkg::GS_CHB]   = evtV[1];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      imaskQ <= alcci_pkg::IMASK_RESET;
    end else begin
      imaskQ <= (imaskQ & ~(idisWr ? regWdata[alcci_pkg::GS_W-1:0] : 5'h00))
              | (ienWr ? regWdata[alcci_pkg::GS_W-1:0] : 5'h00);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(gstat & imaskQ);
    end
  end
  assign irqOut = irqQ;

  genvar k;
  generate
    for (k = 0; k < alcci_pkg::NCHAN; k++) begin : g_chan
      localparam logic [7:0] BASE = 8'(k) * alcci_pkg::CHAN_STRIDE;
      localparam alcci_pkg::alcci_kind_t KIND = (k == 0) ? alcci_pkg::KIND_A :
                                                (k == 1) ? alcci_pkg::KIND_B : alcci_pkg::KIND_CODEC;
      assign chIf[k].modeWr = regWr & hit(regAddr, BASE + alcci_pkg::OFF_MODE);
      assign chIf[k].txWr   = regWr & hit(regAddr, BASE + alcci_pkg::OFF_TXHOLD);
      assign chIf[k].stRd   = regRd & hit(regAddr, BASE + alcci_pkg::OFF_STAT);
      assign chIf[k].rxRd   = regRd & hit(regAddr, BASE + alcci_pkg::OFF_RXHOLD);
      assign chIf[k].wdata  = regWdata;
      assign modeV[k]       = chIf[k].modeQ;
      assign statV[k]       = chIf[k].statQ;
      assign rxV[k]         = chIf[k].rxHoldQ;
      assign evtV[k]        = chIf[k].evt;
      alcci_chan #(
        .KIND (KIND)
      ) u_chan (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .ctl         (chIf[k]),
        .slotReq     (slotReq[k]),
        .slotRxValid (slotRxValid[k]),
        .slotRxData  (slotRxData[k]),
        .varRateOn   (varRateOn),
        .dmaFlags    ((k == 0) ? dmaFlagsA : 4'h0),
        .slotTxData  (slotTxData[k]),
        .slotTxValid (slotTxValid[k]),
        .dmaTxReq    (dmaTxReq[k]),
        .dmaRxReq    (dmaRxReq[k])
      );
    end
  endgenerate

  // mask view and read mux; unmapped and write-only read zero
  always_comb begin
    rdD = 32'h0000_0000;
    for (int i = 0; i < alcci_pkg::NCHAN; i++) begin
      if (regAddr == 8'(i) * alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_MODE) begin
        rdD = modeV[i];
      end
      if (regAddr == 8'(i) * alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_STAT) begin
        rdD = statV[i];
      end
      if (regAddr == 8'(i) * alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_RXHOLD) begin
        rdD = rxV[i];
      end
    end
    if (hit(regAddr, alcci_pkg::OFF_GSTAT)) begin
      rdD = {27'h0000000, gstat};
    end
    if (hit(regAddr, alcci_pkg::OFF_IMASK)) begin
      rdD = {27'h0000000, imaskQ};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? rdD : 32'h0000_0000;
    end
  end

  a_sof_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    frameStart |=> sofQ) else $error("frame start lost");
  a_wake_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    wakeRise |=> wakeQ) else $error("wake edge lost");
  a_read_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
    (gstatRead && !frameStart && !wakeRise) |=> (!sofQ && !wakeQ)) else $error("status read did not clear");
  a_read_shows: assert property (@(posedge core_clk) disable iff (!arst_n)
    gstatRead |=> regRdata == {27'h0000000, $past(gstat)}) else $error("status read wrong");
  a_mask_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    ienWr |=> ((imaskQ & $past(regWdata[4:0])) == $past(regWdata[4:0]))) else $error("mask not set");
  a_mask_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    idisWr |=> ((imaskQ & $past(regWdata[4:0])) == 5'h00)) else $error("mask not cleared");
  a_mask_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!ienWr && !idisWr) |=> $stable(imaskQ)) else $error("mask changed without write");
  a_mask_view: assert property (@(posedge core_clk) disable iff (!arst_n)
    (regRd && hit(regAddr, alcci_pkg::OFF_IMASK)) |=> regRdata == {27'h0000000, $past(imaskQ)})
    else $error("mask view wrong");
  a_irq_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    irqOut == $past(|(gstat & imaskQ))) else $error("irq does not follow masked status");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    !regRd |=> regRdata == 32'h0000_0000) else $error("read data outside read slot");
  a_sof_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!sofQ && !frameStart) |=> !sofQ) else $error("frame flag set without cause");
endmodule

// ---- verif/alcci_codec_model.sv ----
// Purpose: codec side of the link: bit clock, frame sync and serial input pins
// Assumes: bit clock period 200 ns, unrelated in phase to core_clk
// Notes:   bit clock stands low between frames; slot data is driven by the bench
`timescale 1ns/10ps
module alcci_codec_model (
  output logic bitClkPin,
  output logic syncPin,
  output logic sdataInPin
);
  initial begin
    bitClkPin  = 1'b0;
    syncPin    = 1'b0;
    sdataInPin = 1'b0;
  end
  // short frame: sync high over the tag phase, then low; clock only runs inside
  task automatic runFrame(input int nBits);
    for (int i = 0; i < nBits; i++) begin
      syncPin = (i < 16);
      #100 bitClkPin = 1'b1;
      #100 bitClkPin = 1'b0;
    end
    syncPin = 1'b0;
  endtask
  // wake request: serial input rises while the link clock is stopped
  task automatic setWake(input logic v);
    sdataInPin = v;
  endtask
endmodule

// ---- verif/test_alcci_top.sv ----
// Purpose: self-checking bench of the channel config and irq block
// Assumes: register port answers one cycle after the read strobe
// Notes:   expected slot values are computed here, never taken from the design
`timescale 1ns/10ps
module test_alcci_top;
  localparam logic [7:0] A_MODE = alcci_pkg::OFF_MODE;
  localparam logic [7:0] A_ST   = alcci_pkg::OFF_STAT;
  localparam logic [7:0] A_TX   = alcci_pkg::OFF_TXHOLD;
  localparam logic [7:0] B_MODE = alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_MODE;
  localparam logic [7:0] B_ST   = alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_STAT;
  localparam logic [7:0] B_RX   = alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_RXHOLD;
  localparam logic [7:0] B_TX   = alcci_pkg::CHAN_STRIDE + alcci_pkg::OFF_TXHOLD;
  localparam logic [7:0] C_TX   = (alcci_pkg::CHAN_STRIDE << 1) + alcci_pkg::OFF_TXHOLD;
  localparam logic [7:0] C_MODE = (alcci_pkg::CHAN_STRIDE << 1) + alcci_pkg::OFF_MODE;
  localparam logic [7:0] GS     = alcci_pkg::OFF_GSTAT;
  localparam logic [7:0] IEN    = alcci_pkg::OFF_IEN;
  localparam logic [7:0] IDIS   = alcci_pkg::OFF_IDIS;
  localparam logic [7:0] IMASK  = alcci_pkg::OFF_IMASK;
  logic             core_clk;
  logic             arst_n;
  logic [7:0]       regAddr;
  logic [31:0]      regWdata;
  logic             regWr;
  logic             regRd;
  logic [31:0]      regRdata;
  logic             bitClkPin;
  logic             syncPin;
  logic             sdataInPin;
  logic             varRateOn;
  logic [3:0]       dmaFlagsA;
  logic [2:0]       slotReq;
  logic [2:0]       slotRxValid;
  logic [2:0][19:0] slotRxData;
  logic [2:0][19:0] slotTxData;
  logic [2:0]       slotTxValid;
  logic [2:0]       dmaTxReq;
  logic [2:0]       dmaRxReq;
  logic             irqOut;
  int               numErrors;
  int               nCompared;
  logic [31:0]      st;
  alcci_top u_alcci_top (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bitClkPin(bitClkPin), .syncPin(syncPin),
    .sdataInPin(sdataInPin), .varRateOn(varRateOn), .dmaFlagsA(dmaFlagsA), .slotReq(slotReq),
    .slotRxValid(slotRxValid), .slotRxData(slotRxData), .slotTxData(slotTxData),
    .slotTxValid(slotTxValid), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq), .irqOut(irqOut));
  alcci_codec_model u_alcci_codec_model (.bitClkPin(bitClkPin), .syncPin(syncPin), .sdataInPin(sdataInPin));
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask
  task automatic pulseReq(input logic [2:0] m);
    @(posedge core_clk);
    slotReq <= m;
    @(posedge core_clk);
    slotReq <= 3'h0;
    #1;
  endtask
  task automatic pulseRx(input logic [2:0] m, input logic [19:0] d);
    @(posedge core_clk);
    slotRxValid <= m;
    slotRxData  <= {3{d}};
    @(posedge core_clk);
    slotRxValid <= 3'h0;
    tick(2);
  endtask
  function automatic logic [19:0] fmtSlot(input logic [31:0] d, input logic [1:0] sz, input logic sw);
    logic [31:0] w;
    int          n;
    w = sw ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    n = (sz == 2'h0) ? 20 : (sz == 2'h1) ? 18 : (sz == 2'h2) ? 16 : 10;
    fmtSlot = 20'((w & ((32'h1 << n) - 32'h1)) << (20 - n));
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    complete_run();
  end
  initial begin
    {arst_n, regAddr, regWdata, regWr, regRd, varRateOn, dmaFlagsA, slotReq, slotRxValid} = '0;
    slotRxData = '0;
    numErrors  = 0;
    nCompared  = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    rdChk("mode A", A_MODE, 32'h0);
    rdChk("mode codec", C_MODE, 32'h0);
    rdChk("mask view", IMASK, 32'h0);
    check("irq", irqOut, 32'h0);
    $display("test reset done");
    wr(A_MODE, 32'h0000_cc37);
    rdChk("mode A masks", A_MODE, 32'h0000_cc37);
    wr(B_MODE, 32'hffff_ffff);
    rdChk("mode B", B_MODE, alcci_pkg::WMASK_B);
    wr(C_MODE, 32'hffff_ffff);
    rdChk("mode codec", C_MODE, alcci_pkg::WMASK_CODEC);
    wr(A_MODE, 32'h0);
    wr(B_MODE, 32'h0);
    wr(C_MODE, 32'h0);
    rdChk("mode A cleared", A_MODE, 32'h0);
    $display("test mode masks done");
    wr(IEN, 32'h05);
    wr(IEN, 32'h02);
    rdChk("mask set", IMASK, 32'h07);
    wr(IDIS, 32'h04);
    wr(IDIS, 32'h00);
    rdChk("mask clear", IMASK, 32'h03);
    wr(IDIS, 32'h1f);
    rdChk("mask empty", IMASK, 32'h00);
    $display("test irq mask done");
    // tx holding is free after reset, so the bit 0 masks raise all three events
    wr(C_MODE, 32'h1);
    wr(A_MODE, 32'h1);
    wr(B_MODE, 32'h1);
    tick(2);
    rdChk("events", GS, 32'h1c);
    check("irq masked", irqOut, 32'h0);
    wr(IEN, 32'h08);
    tick(3);
    check("irq on", irqOut, 32'h1);
    wr(A_MODE, 32'h0);
    tick(3);
    rdChk("chan A event gone", GS, 32'h14);
    check("irq off", irqOut, 32'h0);
    wr(B_MODE, 32'h0);
    wr(C_MODE, 32'h0);
    wr(IDIS, 32'h08);
    tick(2);
    rdChk("events gone", GS, 32'h00);
    $display("test events done");
    u_alcci_codec_model.runFrame(24);
    tick(10);
    rdChk("frame start", GS, 32'h01);
    rdChk("frame start read", GS, 32'h00);
    u_alcci_codec_model.setWake(1'b1);
    tick(10);
    rdChk("wake", GS, 32'h02);
    rdChk("wake read", GS, 32'h00);
    u_alcci_codec_model.setWake(1'b0);
    $display("test link flags done");
    for (int k = 0; k < 8; k++) begin
      wr(A_MODE, 32'h0020_0000 | (32'(k % 4) << alcci_pkg::POS_SIZE) | (32'(k / 4) << alcci_pkg::POS_ENDIAN));
      wr(A_TX, 32'h12a5_c3e7);
      pulseReq(3'h1);
      check("tx valid", slotTxValid[0], 32'h1);
      check("tx slot", slotTxData[0], fmtSlot(32'h12a5_c3e7, 2'(k % 4), 1'(k / 4)));
    end
    // holding left full, then disabled: the request must still be refused
    wr(A_TX, 32'h0001_1111);
    wr(A_MODE, 32'h0);
    pulseReq(3'h1);
    check("tx disabled", slotTxValid[0], 32'h0);
    wr(B_MODE, 32'h0022_0000);
    wr(B_TX, 32'h12a5_c3e7);
    wr(C_TX, 32'h12a5_c3e7);
    pulseReq(3'h6);
    check("tx slot B", slotTxData[1], fmtSlot(32'h12a5_c3e7, 2'h2, 1'b0));
    check("tx slot codec", slotTxData[2], fmtSlot(32'h12a5_c3e7, 2'h0, 1'b0));
    check("tx valid codec", slotTxValid[2], 32'h1);
    $display("test tx slots done");
    wr(B_MODE, 32'h0020_0000);
    pulseRx(3'h2, 20'habcde);
    rd(B_ST, st);
    check("rx full", st[alcci_pkg::BIT_RX_FULL], 32'h1);
    wr(B_MODE, 32'h0024_0000);
    pulseRx(3'h2, 20'h13579);
    rd(B_ST, st);
    check("overflow", st[alcci_pkg::BIT_RX_OVER], 32'h1);
    rd(B_ST, st);
    check("overflow read", st[alcci_pkg::BIT_RX_OVER], 32'h0);
    rdChk("rx data swapped", B_RX, 32'h7935_0100);
    rd(B_ST, st);
    check("rx empty", st[alcci_pkg::BIT_RX_FULL], 32'h0);
    wr(A_MODE, 32'h0020_0000);
    pulseReq(3'h1);
    check("tx resumes", slotTxData[0], 32'h0001_1111);
    pulseReq(3'h1);
    rd(A_ST, st);
    check("no underflow", st[alcci_pkg::BIT_TX_UNDER], 32'h0);
    @(posedge core_clk);
    varRateOn <= 1'b1;
    pulseReq(3'h1);
    rd(A_ST, st);
    check("underflow", st[alcci_pkg::BIT_TX_UNDER], 32'h1);
    rd(A_ST, st);
    check("underflow read", st[alcci_pkg::BIT_TX_UNDER], 32'h0);
    $display("test rx and status done");
    @(posedge core_clk);
    dmaFlagsA <= 4'hf;
    wr(A_MODE, 32'h0060_0000);
    pulseRx(3'h1, 20'h0f0f0);
    rd(A_ST, st);
    check("dma flags", st & 32'h0000_cc00, 32'h0000_cc00);
    check("dma tx req", dmaTxReq[0], 32'h1);
    check("dma rx req", dmaRxReq[0], 32'h1);
    wr(A_MODE, 32'h0020_0000);
    tick(3);
    rd(A_ST, st);
    check("dma flags off", st & 32'h0000_cc00, 32'h0);
    check("dma tx req off", dmaTxReq[0], 32'h0);
    check("dma rx req off", dmaRxReq[0], 32'h0);
    $display("test dma routing done");
    complete_run();
  end
endmodule
